// File: shared/mex_pkg.sv
// package for the skip, subtract, swap, table read and xor execution block
package mex_pkg;
   localparam int DATA_W = 8;
   localparam int PROG_W = 16;
   localparam int PAGE_W = 8;
   localparam logic [7:0] BYTE_ONES = 8'hFF;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_ONE  = 8'h01;
   localparam logic [3:0] FLAGS_RST = 4'h0;
   localparam logic [7:0] ACC_RST   = 8'h00;

   typedef enum logic [4:0] {
      OP_NONE, OP_DEC_SKIP_ACC, OP_INC_SKIP, OP_INC_SKIP_ACC, OP_SET_BYTE,
      OP_SET_BIT, OP_SKIP_BIT_NZ, OP_SKIP_BIT_Z, OP_SKIP_ZERO, OP_SKIP_ZERO_LOAD,
      OP_SUB_MEM, OP_SUB_TO_MEM, OP_SUB_IMM, OP_SWAP, OP_SWAP_ACC,
      OP_TABLE_READ, OP_TABLE_READ_LAST, OP_XOR_MEM, OP_XOR_TO_MEM, OP_XOR_IMM
   } mex_op_t;

   // one decoded instruction from the core
   typedef struct packed {
      mex_op_t    op;
      logic [2:0] bit_sel;
      logic [7:0] operand;
      logic [7:0] literal;
   } mex_instr_t;

   // status flags kept by this block
   typedef struct packed {
      logic signed_wrap_flag;
      logic zero;
      logic nibble_carry_flag;
      logic carry;
   } mex_flags_t;

   // data memory write request
   typedef struct packed {
      logic       en;
      logic [7:0] data;
   } mex_mem_wr_t;
endpackage

// File: verilog/mex_subtract.sv
// eight bit subtractor with overflow, zero, nibble carry and carry flags
`timescale 1ns/10ps
`default_nettype none
module mex_subtract
   import mex_pkg::*;
(
   input  wire logic [7:0] min_in,
   input  wire logic [7:0] sub_in,
   output logic [7:0]      diff_out,
   output mex_flags_t      flags_out
);
   logic [8:0] full_diff;
   logic [4:0] low_diff;

   // carry is the inverse of borrow
   always_comb begin
      full_diff = {1'b0, min_in} - {1'b0, sub_in};
      low_diff  = {1'b0, min_in[3:0]} - {1'b0, sub_in[3:0]};
      diff_out  = full_diff[7:0];
      flags_out.carry             = ~full_diff[8];
      flags_out.nibble_carry_flag = ~low_diff[4];
      flags_out.zero              = (full_diff[7:0] == BYTE_ZERO);
      flags_out.signed_wrap_flag  = (min_in[7] ^ sub_in[7]) & (min_in[7] ^ full_diff[7]);
   end
endmodule
`default_nettype wire

// File: verilog/mex_exec.sv
// execution unit for skip, subtract, swap, table read and xor instructions
`timescale 1ns/10ps
`default_nettype none
module mex_exec
   import mex_pkg::*;
#(
   parameter int PROG_AW = 12
)(
   input  wire logic               clock_in,
   input  wire logic               rst_n_in,
   input  wire logic               issue_in,
   input  wire mex_instr_t         instr_in,
   input  wire logic [7:0]         table_pointer_low_in,
   input  wire logic [7:0]         table_pointer_high_in,
   input  wire logic [PROG_W-1:0]  prog_word_in,
   output logic [PROG_AW-1:0]      prog_addr_out,
   output mex_mem_wr_t             mem_wr_out,
   output logic [7:0]              acc_out,
   output mex_flags_t              flags_out,
   output logic [7:0]              table_read_high_byte_out,
   output logic                    skip_out,
   output logic                    busy_out
);
   typedef enum logic [1:0] {ST_IDLE, ST_TABLE, ST_DUMMY} mex_state_t;

   mex_state_t  state_ff, nxt_state;
   logic [7:0]  acc_ff, nxt_acc;
   mex_flags_t  flags_ff, nxt_flags;
   logic [7:0]  table_read_high_byte_ff, nxt_table_read_high_byte;
   mex_mem_wr_t wr_ff, nxt_wr;
   logic        skip_ff, nxt_skip;
   logic [PROG_AW-1:0] paddr_ff, nxt_paddr;
   logic [7:0]  sub_b, sub_diff;
   mex_flags_t  sub_flags;

   function automatic logic is_zero(input logic [7:0] v);
      return v == BYTE_ZERO;
   endfunction

   function automatic logic [7:0] swap_nib(input logic [7:0] v);
      return {v[3:0], v[7:4]};
   endfunction

   // subtrahend is the literal for the immediate form
   assign sub_b = (instr_in.op == OP_SUB_IMM) ? instr_in.literal : instr_in.operand;

   mex_subtract u_sub (
      .min_in    (acc_ff),
      .sub_in    (sub_b),
      .diff_out  (sub_diff),
      .flags_out (sub_flags)
   );

   // next state, results and skip decision
   always_comb begin
      logic [7:0] r;
      logic       sk;
      r         = BYTE_ZERO;
      sk        = 1'b0;
      nxt_state = state_ff;
      nxt_acc   = acc_ff;
      nxt_flags = flags_ff;
      nxt_table_read_high_byte  = table_read_high_byte_ff;
      nxt_wr    = '0;
      nxt_skip  = 1'b0;
      nxt_paddr = paddr_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (issue_in) begin
               unique case (instr_in.op)
                  OP_DEC_SKIP_ACC: begin
                     r = instr_in.operand - BYTE_ONE;
                     nxt_acc = r;
                     sk = is_zero(r);
                  end
                  OP_INC_SKIP: begin
                     r = instr_in.operand + BYTE_ONE;
                     nxt_wr = '{en: 1'b1, data: r};
                     sk = is_zero(r);
                  end
                  OP_INC_SKIP_ACC: begin
                     r = instr_in.operand + BYTE_ONE;
                     nxt_acc = r;
                     sk = is_zero(r);
                  end
                  OP_SET_BYTE: nxt_wr = '{en: 1'b1, data: BYTE_ONES};
                  OP_SET_BIT: begin
                     r = instr_in.operand;
                     r[instr_in.bit_sel] = 1'b1;
                     nxt_wr = '{en: 1'b1, data: r};
                  end
                  OP_SKIP_BIT_NZ: sk = instr_in.operand[instr_in.bit_sel];
                  OP_SKIP_BIT_Z: sk = ~instr_in.operand[instr_in.bit_sel];
                  OP_SKIP_ZERO: sk = is_zero(instr_in.operand);
                  OP_SKIP_ZERO_LOAD: begin
                     nxt_acc = instr_in.operand;
                     sk = is_zero(instr_in.operand);
                  end
                  OP_SUB_MEM, OP_SUB_IMM: begin
                     nxt_acc = sub_diff;
                     nxt_flags = sub_flags;
                  end
                  OP_SUB_TO_MEM: begin
                     nxt_wr = '{en: 1'b1, data: sub_diff};
                     nxt_flags = sub_flags;
                  end
                  OP_SWAP: nxt_wr = '{en: 1'b1, data: swap_nib(instr_in.operand)};
                  OP_SWAP_ACC: nxt_acc = swap_nib(instr_in.operand);
                  OP_TABLE_READ: begin
                     // full pointer, upper bits cut to program size
                     nxt_paddr = PROG_AW'({table_pointer_high_in, table_pointer_low_in});
                     nxt_state = ST_TABLE;
                  end
                  OP_TABLE_READ_LAST: begin
                     nxt_paddr = {{(PROG_AW-PAGE_W){1'b1}}, table_pointer_low_in};
                     nxt_state = ST_TABLE;
                  end
                  OP_XOR_MEM, OP_XOR_IMM: begin
                     r = acc_ff ^ ((instr_in.op == OP_XOR_IMM) ? instr_in.literal
                                                                : instr_in.operand);
                     nxt_acc = r;
                     nxt_flags.zero = is_zero(r);
                  end
                  OP_XOR_TO_MEM: begin
                     r = acc_ff ^ instr_in.operand;
                     nxt_wr = '{en: 1'b1, data: r};
                     nxt_flags.zero = is_zero(r);
                  end
                  default: ;
               endcase
               if (sk) begin
                  nxt_skip  = 1'b1;
                  nxt_state = ST_DUMMY;
               end
            end
         end
         // program word is taken in the same cycle that the address is presented
         ST_TABLE: begin
            nxt_wr    = '{en: 1'b1, data: prog_word_in[7:0]};
            nxt_table_read_high_byte  = prog_word_in[15:8];
            nxt_state = ST_IDLE;
         end
         // dummy cycle while the following instruction is discarded
         ST_DUMMY: nxt_state = ST_IDLE;
         default: nxt_state = ST_IDLE;
      endcase
   end

   // register all state
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_ff <= ST_IDLE;
         acc_ff   <= ACC_RST;
         flags_ff <= FLAGS_RST;
         table_read_high_byte_ff  <= BYTE_ZERO;
         wr_ff    <= '0;
         skip_ff  <= 1'b0;
         paddr_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         acc_ff   <= nxt_acc;
         flags_ff <= nxt_flags;
         table_read_high_byte_ff  <= nxt_table_read_high_byte;
         wr_ff    <= nxt_wr;
         skip_ff  <= nxt_skip;
         paddr_ff <= nxt_paddr;
      end
   end

   assign acc_out                  = acc_ff;
   assign flags_out                = flags_ff;
   assign table_read_high_byte_out = table_read_high_byte_ff;
   assign mem_wr_out               = wr_ff;
   assign skip_out                 = skip_ff;
   assign prog_addr_out            = paddr_ff;
   // issue must be held off while busy; the core sees this as a stall
   assign busy_out                 = (state_ff != ST_IDLE);

   // skip lasts exactly one dummy cycle
   skip_two_cycle_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      skip_ff |-> busy_out ##1 !busy_out)
      else $error("skip did not insert one dummy cycle");

   // byte set writes all ones, flags kept
   set_byte_write_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (issue_in && !busy_out && instr_in.op == OP_SET_BYTE) |=>
      (mem_wr_out.en && mem_wr_out.data == BYTE_ONES && flags_out == $past(flags_out)))
      else $error("byte set wrong");

   // increment skip writes back and skips on wrap
   inc_skip_wrap_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (issue_in && !busy_out && instr_in.op == OP_INC_SKIP && instr_in.operand == BYTE_ONES)
      |=> (skip_out && mem_wr_out.en && mem_wr_out.data == BYTE_ZERO))
      else $error("increment skip wrong on wrap");

   // decrement skip to acc leaves memory alone
   dec_skip_acc_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (issue_in && !busy_out && instr_in.op == OP_DEC_SKIP_ACC) |=>
      (!mem_wr_out.en && skip_out == (acc_out == BYTE_ZERO)))
      else $error("decrement skip to acc wrong");

   // subtraction carry follows borrow
   sub_carry_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (issue_in && !busy_out && instr_in.op == OP_SUB_MEM) |=>
      (flags_out.carry == ($past(acc_out) >= $past(instr_in.operand))))
      else $error("subtract carry wrong");

   // bit zero skip follows the selected bit
   bit_zero_skip_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (issue_in && !busy_out && instr_in.op == OP_SKIP_BIT_Z) |=>
      (skip_out != $past(instr_in.operand[instr_in.bit_sel])))
      else $error("bit zero skip wrong");

   // table read lands two cycles after issue
   table_read_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (issue_in && !busy_out && instr_in.op == OP_TABLE_READ) |=> busy_out ##1
      (mem_wr_out.en && table_read_high_byte_out == $past(prog_word_in[15:8])))
      else $error("table read wrong");

   // xor immediate sets only zero flag
   xor_imm_zero_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (issue_in && !busy_out && instr_in.op == OP_XOR_IMM) |=>
      (flags_out.zero == (acc_out == BYTE_ZERO) && flags_out.carry == $past(flags_out.carry)))
      else $error("xor immediate flags wrong");

   // skip on a zero byte changes nothing else
   skip_zero_keep_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (issue_in && !busy_out && instr_in.op == OP_SKIP_ZERO) |=>
      (!mem_wr_out.en && acc_out == $past(acc_out) && flags_out == $past(flags_out)
       && skip_out == ($past(instr_in.operand) == BYTE_ZERO)))
      else $error("byte zero skip wrong");

   // increment skip to acc leaves memory alone and skips on zero
   inc_acc_skip_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (issue_in && !busy_out && instr_in.op == OP_INC_SKIP_ACC) |=>
      (!mem_wr_out.en && acc_out == $past(instr_in.operand) + BYTE_ONE
       && skip_out == (acc_out == BYTE_ZERO)))
      else $error("increment skip to acc wrong");

   // zero test with load copies the operand, flags kept
   zero_load_acc_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (issue_in && !busy_out && instr_in.op == OP_SKIP_ZERO_LOAD) |=>
      (acc_out == $past(instr_in.operand) && skip_out == (acc_out == BYTE_ZERO)
       && flags_out == $past(flags_out)))
      else $error("zero test with load wrong");

   // bit set adds one bit and keeps the rest
   bit_set_write_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (issue_in && !busy_out && instr_in.op == OP_SET_BIT) |=>
      (mem_wr_out.en && flags_out == $past(flags_out) && mem_wr_out.data ==
       ($past(instr_in.operand) | (BYTE_ONE << $past(instr_in.bit_sel)))))
      else $error("bit set wrong");

   // bit nonzero skip follows the selected bit
   bit_nz_skip_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (issue_in && !busy_out && instr_in.op == OP_SKIP_BIT_NZ) |=>
      (skip_out == $past(instr_in.operand[instr_in.bit_sel])))
      else $error("bit nonzero skip wrong");

   // subtract to memory stores the difference and keeps the accumulator
   sub_mem_store_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (issue_in && !busy_out && instr_in.op == OP_SUB_TO_MEM) |=>
      (mem_wr_out.en && mem_wr_out.data == $past(acc_out) - $past(instr_in.operand)
       && acc_out == $past(acc_out) && flags_out.zero == (mem_wr_out.data == BYTE_ZERO)))
      else $error("subtract to memory wrong");

   // immediate subtract uses the literal, not the memory byte
   sub_imm_result_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (issue_in && !busy_out && instr_in.op == OP_SUB_IMM) |=>
      (acc_out == $past(acc_out) - $past(instr_in.literal) && !mem_wr_out.en
       && flags_out.carry == ($past(acc_out) >= $past(instr_in.literal))))
      else $error("immediate subtract wrong");

   // nibble swap in memory, flags kept
   swap_mem_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (issue_in && !busy_out && instr_in.op == OP_SWAP) |=>
      (mem_wr_out.en && flags_out == $past(flags_out) && mem_wr_out.data ==
       {$past(instr_in.operand[3:0]), $past(instr_in.operand[7:4])}))
      else $error("nibble swap wrong");

   // nibble swap to acc keeps memory
   swap_acc_keep_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (issue_in && !busy_out && instr_in.op == OP_SWAP_ACC) |=>
      (!mem_wr_out.en && acc_out ==
       {$past(instr_in.operand[3:0]), $past(instr_in.operand[7:4])}))
      else $error("nibble swap to acc wrong");

   // xor into acc moves only the zero flag
   xor_mem_zero_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (issue_in && !busy_out && instr_in.op == OP_XOR_MEM) |=>
      (acc_out == ($past(acc_out) ^ $past(instr_in.operand))
       && flags_out.zero == (acc_out == BYTE_ZERO)
       && flags_out.carry == $past(flags_out.carry)))
      else $error("xor memory wrong");

   // xor to memory keeps the accumulator, zero flag from the result
   xor_mem_store_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (issue_in && !busy_out && instr_in.op == OP_XOR_TO_MEM) |=>
      (mem_wr_out.en && mem_wr_out.data == ($past(acc_out) ^ $past(instr_in.operand))
       && acc_out == $past(acc_out) && flags_out.zero == (mem_wr_out.data == BYTE_ZERO)))
      else $error("xor to memory wrong");

   // last page read: upper address bits all ones, low byte from the pointer
   last_page_addr_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (issue_in && !busy_out && instr_in.op == OP_TABLE_READ_LAST) |=>
      (busy_out && prog_addr_out[PAGE_W-1:0] == $past(table_pointer_low_in)
       && (&prog_addr_out[PROG_AW-1:PAGE_W])))
      else $error("last page table read address wrong");

   // an issue in the dummy cycle is dropped, so the skipped word never executes
   dummy_refuse_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (issue_in && state_ff == ST_DUMMY) |=>
      (!mem_wr_out.en && !skip_out && !busy_out && acc_out == $past(acc_out)))
      else $error("issue in dummy cycle not dropped");
endmodule
`default_nettype wire

// File: test/mex_prog_model.sv
// program memory model answering table reads from the execution block
`timescale 1ns/10ps
`default_nettype none
module mex_prog_model
   import mex_pkg::*;
#(
   parameter int AW = 12
)(
   input  wire logic [AW-1:0]     addr_in,
   output logic      [PROG_W-1:0] word_out
);
   // both address halves show up in the word, so a wrong page or a swapped byte is seen
   assign word_out = {addr_in[7:0] ^ 8'h5A, addr_in[AW-1:AW-8]};
endmodule
`default_nettype wire

// File: test/testbench.sv
// self-checking testbench for the skip, subtract, swap, table read and xor block
`timescale 1ns/10ps
`default_nettype none
module testbench
   import mex_pkg::*;
;
   logic              clock_in = 1'b0;
   logic              rst_n_in = 1'b0;
   logic              issue = 1'b0;
   mex_instr_t        instr = '0;
   logic [7:0]        tp_low = 8'h00;
   logic [7:0]        tp_high = 8'h00;
   logic [15:0]       prog_word;
   logic [11:0]       prog_addr;
   mex_mem_wr_t       mem_wr;
   logic [7:0]        acc;
   mex_flags_t        flags;
   logic [7:0]        table_read_high_byte;
   logic              skip;
   logic              busy;
   int                errors = 0;
   int                checked = 0;

   // 125 MHz clock
   always #4 clock_in = ~clock_in;

   mex_exec #(.PROG_AW(12)) i_dut (
      .clock_in(clock_in), .rst_n_in(rst_n_in), .issue_in(issue), .instr_in(instr),
      .table_pointer_low_in(tp_low), .table_pointer_high_in(tp_high),
      .prog_word_in(prog_word), .prog_addr_out(prog_addr), .mem_wr_out(mem_wr),
      .acc_out(acc), .flags_out(flags), .table_read_high_byte_out(table_read_high_byte),
      .skip_out(skip), .busy_out(busy));

   mex_prog_model #(.AW(12)) i_prog (.addr_in(prog_addr), .word_out(prog_word));

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // issue one instruction at the next idle edge; returns one edge later, when all but table read results have landed
   task automatic exec(input mex_op_t op, input logic [2:0] b, input logic [7:0] m,
                       input logic [7:0] l);
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 10) begin
         @(posedge clock_in);
         #1;
         n++;
      end
      if (busy !== 1'b0) begin
         errors++;
         wrap_up();
      end else begin
         instr = '{op: op, bit_sel: b, operand: m, literal: l};
         issue = 1'b1;
         @(posedge clock_in);
         #1;
         issue = 1'b0;
      end
   endtask

   // accumulator, memory write and skip seen together one cycle after issue
   task automatic outs(input logic [7:0] a, input logic [8:0] w, input logic s);
      check("acc", {8'h00, acc}, {8'h00, a});
      check("mem_wr", {7'h00, mem_wr}, {7'h00, w});
      check("skip", {15'h0000, skip}, {15'h0000, s});
   endtask

   task automatic t_skips();
      exec(OP_SKIP_ZERO_LOAD, 3'h0, 8'h00, 8'h00);
      outs(8'h00, 9'h000, 1'b1);
      check("busy", {15'h0000, busy}, 16'h0001);
      exec(OP_SKIP_ZERO_LOAD, 3'h0, 8'h05, 8'h00);
      outs(8'h05, 9'h000, 1'b0);
      exec(OP_DEC_SKIP_ACC, 3'h0, 8'h01, 8'h00);
      outs(8'h00, 9'h000, 1'b1);
      exec(OP_DEC_SKIP_ACC, 3'h0, 8'h00, 8'h00);
      outs(8'hFF, 9'h000, 1'b0);
      exec(OP_INC_SKIP_ACC, 3'h0, 8'hFF, 8'h00);
      outs(8'h00, 9'h000, 1'b1);
      exec(OP_INC_SKIP, 3'h0, 8'hFE, 8'h00);
      outs(8'h00, 9'h1FF, 1'b0);
      exec(OP_INC_SKIP, 3'h0, 8'hFF, 8'h00);
      outs(8'h00, 9'h100, 1'b1);
      exec(OP_SKIP_ZERO, 3'h0, 8'h80, 8'h00);
      outs(8'h00, 9'h000, 1'b0);
      exec(OP_SKIP_BIT_NZ, 3'h3, 8'h08, 8'h00);
      outs(8'h00, 9'h000, 1'b1);
      exec(OP_SKIP_BIT_NZ, 3'h7, 8'h7F, 8'h00);
      outs(8'h00, 9'h000, 1'b0);
      exec(OP_SKIP_BIT_Z, 3'h3, 8'hF7, 8'h00);
      outs(8'h00, 9'h000, 1'b1);
      exec(OP_SKIP_BIT_Z, 3'h0, 8'h01, 8'h00);
      outs(8'h00, 9'h000, 1'b0);
      $display("test skips done");
   endtask

   task automatic t_subtract();
      exec(OP_SKIP_ZERO_LOAD, 3'h0, 8'h05, 8'h00);
      exec(OP_SUB_IMM, 3'h0, 8'h00, 8'h06);
      outs(8'hFF, 9'h000, 1'b0);
      check("flags", {12'h000, flags}, 16'h0000);
      exec(OP_SUB_MEM, 3'h0, 8'h05, 8'h00);
      outs(8'hFA, 9'h000, 1'b0);
      check("flags", {12'h000, flags}, 16'h0003);
      exec(OP_SKIP_ZERO_LOAD, 3'h0, 8'h80, 8'h00);
      exec(OP_SUB_IMM, 3'h0, 8'h00, 8'h01);
      check("flags", {12'h000, flags}, 16'h0009);
      exec(OP_SUB_TO_MEM, 3'h0, 8'h7F, 8'h00);
      outs(8'h7F, 9'h100, 1'b0);
      check("flags", {12'h000, flags}, 16'h0007);
      $display("test subtract done");
   endtask

   task automatic t_bits_xor();
      exec(OP_SET_BYTE, 3'h0, 8'h12, 8'h00);
      outs(8'h7F, 9'h1FF, 1'b0);
      exec(OP_SET_BIT, 3'h2, 8'h41, 8'h00);
      outs(8'h7F, 9'h145, 1'b0);
      exec(OP_SWAP, 3'h0, 8'h3C, 8'h00);
      outs(8'h7F, 9'h1C3, 1'b0);
      exec(OP_SWAP_ACC, 3'h0, 8'h12, 8'h00);
      outs(8'h21, 9'h000, 1'b0);
      check("flags", {12'h000, flags}, 16'h0007);
      exec(OP_XOR_MEM, 3'h0, 8'h21, 8'h00);
      outs(8'h00, 9'h000, 1'b0);
      check("flags", {12'h000, flags}, 16'h0007);
      exec(OP_XOR_IMM, 3'h0, 8'h00, 8'h0F);
      outs(8'h0F, 9'h000, 1'b0);
      check("flags", {12'h000, flags}, 16'h0003);
      exec(OP_XOR_TO_MEM, 3'h0, 8'hF5, 8'h00);
      outs(8'h0F, 9'h1FA, 1'b0);
      exec(OP_XOR_TO_MEM, 3'h0, 8'h0F, 8'h00);
      outs(8'h0F, 9'h100, 1'b0);
      check("flags", {12'h000, flags}, 16'h0007);
      $display("test bits and xor done");
   endtask

   task automatic t_table(input mex_op_t op, input logic [7:0] hi, input logic [7:0] lo,
                          input logic [11:0] a);
      logic [15:0] w;
      w = {a[7:0] ^ 8'h5A, a[11:4]};
      tp_high = hi;
      tp_low = lo;
      exec(op, 3'h0, 8'h00, 8'h00);
      check("prog_addr", {4'h0, prog_addr}, {4'h0, a});
      @(posedge clock_in);
      #1;
      check("mem_wr", {7'h00, mem_wr}, {8'h01, w[7:0]});
      check("table_read_high_byte", {8'h00, table_read_high_byte}, {8'h00, w[15:8]});
      $display("test table read done");
   endtask

   // issue held into the dummy cycle is dropped; reset in a dummy cycle returns to idle
   task automatic t_refuse_reset();
      instr = '{op: OP_SKIP_ZERO, bit_sel: 3'h0, operand: 8'h00, literal: 8'h00};
      issue = 1'b1;
      @(posedge clock_in);
      #1;
      check("skip", {15'h0000, skip}, 16'h0001);
      instr = '{op: OP_SET_BYTE, bit_sel: 3'h0, operand: 8'h00, literal: 8'h00};
      @(posedge clock_in);
      #1;
      issue = 1'b0;
      check("mem_wr", {7'h00, mem_wr}, 16'h0000);
      check("skip", {15'h0000, skip}, 16'h0000);
      check("busy", {15'h0000, busy}, 16'h0000);
      exec(OP_SKIP_BIT_NZ, 3'h1, 8'h02, 8'h00);
      check("busy", {15'h0000, busy}, 16'h0001);
      rst_n_in = 1'b0;
      @(posedge clock_in);
      #1;
      check("busy", {15'h0000, busy}, 16'h0000);
      check("skip", {15'h0000, skip}, 16'h0000);
      rst_n_in = 1'b1;
      exec(OP_SKIP_ZERO_LOAD, 3'h0, 8'h33, 8'h00);
      outs(8'h33, 9'h000, 1'b0);
      check("flags", {12'h000, flags}, 16'h0000);
      $display("test refuse and reset done");
   endtask

   // reset, then each scenario in turn
   initial begin
      repeat (16) @(posedge clock_in);
      #1;
      rst_n_in = 1'b1;
      t_skips();
      t_subtract();
      t_bits_xor();
      t_table(OP_TABLE_READ, 8'h03, 8'h45, 12'h345);
      t_table(OP_TABLE_READ_LAST, 8'h03, 8'h9A, 12'hF9A);
      t_refuse_reset();
      wrap_up();
   end
endmodule
`default_nettype wire
